//--- hdl/fad_pkg.sv
// Package for the range and aperture delay register bank.
// Assumes a single 25 MHz clock domain and an Avalon-MM slave with 32-bit data.
package fad_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] FAD_IDX_RANGE  = 4'hB;  // Range adjust register index
  localparam logic [3:0] FAD_IDX_COARSE = 4'hC;  // Coarse delay register index
  localparam logic [3:0] FAD_IDX_FINE   = 4'hD;  // Fine delay register index
  localparam int         FAD_ADDR_W     = 8;     // Byte address width
  localparam int         FAD_REG_W      = 16;    // Register width

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [15:0] FAD_RST_RANGE  = 16'h4000;
  localparam logic [15:0] FAD_RST_COARSE = 16'h0004;
  localparam logic [15:0] FAD_RST_FINE   = 16'h0000;

  // ****************************************************
  // Field positions and widths
  // ****************************************************
  localparam int FAD_RANGE_W     = 15;  // Range field, bits 14:0
  localparam int FAD_COARSE_LSB  = 4;   // Coarse magnitude, bits 15:4
  localparam int FAD_COARSE_W    = 12;
  localparam int FAD_ENA_BIT     = 3;   // Delay adjust enable
  localparam int FAD_DCS_BIT     = 2;   // Duty stabilizer enable
  localparam int FAD_FINE_LSB    = 10;  // Fine magnitude, bits 15:10
  localparam int FAD_FINE_W      = 6;

  // Coarse codes above this saturate to it
  localparam logic [11:0] FAD_COARSE_MAX = 12'h97F;  // 2431
  localparam logic [14:0] FAD_RANGE_MID  = 15'h4000; // 16384, nominal range

  // Bus handshake state
  typedef enum logic [1:0] {
    FAD_IDLE = 2'b00,
    FAD_ACK  = 2'b01
  } fad_state_t;

  // Byte address of a register index
  function automatic logic [7:0] fad_byte_addr(input logic [3:0] idx);
    fad_byte_addr = {2'b00, idx, 2'b00};
  endfunction

endpackage

//--- hdl/fad_cfg_if.sv
// Interface carrying stored register words and static control vectors between modules.
// Assumes one clock domain; no timing of its own.
`timescale 1ns/1ps
interface fad_cfg_if;
  logic [15:0] range_word;    // Stored range register
  logic [15:0] coarse_word;   // Stored coarse register
  logic [15:0] fine_word;     // Stored fine register
  logic [14:0] range_magnitude;
  logic [11:0] coarse_delay_magnitude;
  logic [5:0]  fine_delay_magnitude;
  logic        delay_adjust_enable;
  logic        duty_stabilizer_enable;

  modport regs (output range_word, output coarse_word, output fine_word);
  modport dec  (input range_word, input coarse_word, input fine_word,
                output range_magnitude, output coarse_delay_magnitude,
                output fine_delay_magnitude, output delay_adjust_enable,
                output duty_stabilizer_enable);
endinterface

//--- hdl/fad_field_decode.sv
// Field decoder: turns stored words into applied analog control vectors.
// Assumes the register words are stable outputs of flip-flops.
`timescale 1ns/1ps
module fad_field_decode
  import fad_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  fad_cfg_if.dec    cfg
);

  logic [11:0] coarse_raw;  // Coarse code as written
  logic        ena_raw;     // Adjust enable as written

  assign coarse_raw = cfg.coarse_word[FAD_COARSE_LSB +: FAD_COARSE_W];
  assign ena_raw    = cfg.coarse_word[FAD_ENA_BIT];

  // ****************************************************
  // Applied vectors, registered so outputs come from flops
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.range_magnitude        <= FAD_RST_RANGE[14:0];
      cfg.coarse_delay_magnitude <= 12'h000;
      cfg.fine_delay_magnitude   <= 6'h00;
      cfg.delay_adjust_enable    <= 1'b0;
      cfg.duty_stabilizer_enable <= 1'b1;
    end else if (ce) begin
      // RQ1 range field drive
      cfg.range_magnitude <= cfg.range_word[FAD_RANGE_W-1:0];
      // RQ6 enable gates both
      if (ena_raw) begin
        // RQ5 saturate coarse code
        cfg.coarse_delay_magnitude <= (coarse_raw > FAD_COARSE_MAX) ? FAD_COARSE_MAX : coarse_raw;
        // RQ8 fine field drive
        cfg.fine_delay_magnitude <= cfg.fine_word[FAD_FINE_LSB +: FAD_FINE_W];
      end else begin
        // Neither magnitude applies while disabled
        cfg.coarse_delay_magnitude <= 12'h000;
        cfg.fine_delay_magnitude   <= 6'h00;
      end
      cfg.delay_adjust_enable <= ena_raw;
      // RQ7 stabilizer control bit
      cfg.duty_stabilizer_enable <= cfg.coarse_word[FAD_DCS_BIT];
    end
  end

  // RQ5 saturation check
  AST_COARSE_SAT: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ena_raw && coarse_raw > FAD_COARSE_MAX |=> cfg.coarse_delay_magnitude == FAD_COARSE_MAX) // RQ5
    else $error("Coarse delay did not saturate");

  // RQ6 disabled means zero
  AST_ENA_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !ena_raw |=> cfg.coarse_delay_magnitude == 12'h000 && cfg.fine_delay_magnitude == 6'h00) // RQ6
    else $error("Delay magnitude applied while disabled");

  // RQ8 fine follows field
  AST_FINE_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ena_raw |=> cfg.fine_delay_magnitude == $past(cfg.fine_word[15:10])) // RQ8
    else $error("Fine delay not applied");

  // RQ4 coarse passes in range
  AST_COARSE_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ena_raw && coarse_raw <= FAD_COARSE_MAX |=> cfg.coarse_delay_magnitude == $past(coarse_raw)) // RQ4
    else $error("Coarse delay not applied linearly");

  // RQ7 stabilizer follows bit
  AST_DCS: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> cfg.duty_stabilizer_enable == $past(cfg.coarse_word[2])) // RQ7
    else $error("Stabilizer enable mismatch");

endmodule

//--- hdl/fad_regs.sv
// Top of the range and aperture delay register bank, Avalon-MM slave.
// Assumes a 25 MHz clock, asynchronous active-low reset, and a master that
// holds its request until waitrequest is seen low.
`timescale 1ns/1ps

// What this block does
// RQ1 - Range field is low fifteen bits
// RQ2 - Range resets to mid code 16384
// RQ3 - Software keeps reserved bits as required
// RQ4 - Coarse delay is bits 15 to 4
// RQ5 - Coarse codes above 2431 saturate
// RQ6 - Bit 3 enables coarse and fine
// RQ7 - Bit 2 enables duty stabilizer, default on
// RQ8 - Fine delay is top six bits
// RQ9 - Registers reset, read back, drive continuously
module fad_regs
  import fad_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic [FAD_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic      [1:0]            avs_response,
  output logic                       avs_waitrequest,
  output logic      [14:0]           range_magnitude,
  output logic      [11:0]           coarse_delay_magnitude,
  output logic      [5:0]            fine_delay_magnitude,
  output logic                       delay_adjust_enable,
  output logic                       duty_stabilizer_enable
);
  import fad_pkg::*;

  // ****************************************************
  // Storage and handshake state
  // ****************************************************
  fad_cfg_if   cfg ();            // Words and applied vectors
  logic [15:0] range_reg;         // Range adjust register
  logic [15:0] coarse_reg;        // Coarse delay register
  logic [15:0] fine_reg;          // Fine delay register
  fad_state_t  state_reg;         // Handshake state
  logic [31:0] rdata_reg;         // Captured read data
  logic [1:0]  resp_reg;          // Captured response
  logic        hit_range;         // Address decode
  logic        hit_coarse;
  logic        hit_fine;
  logic        hit_any;
  logic        req;               // A request is pending
  logic        take;              // Request completes this edge

  // One cycle of wait: the answer comes the edge after the request is seen.
  // This keeps read data registered at a small latency cost.
  assign req  = avs_read || avs_write;
  assign take = ce && (state_reg == FAD_ACK) && req;

  // Address decoding
  always_comb begin
    hit_range  = 1'b0;
    hit_coarse = 1'b0;
    hit_fine   = 1'b0;
    if (avs_address == fad_byte_addr(FAD_IDX_RANGE)) begin
      hit_range = 1'b1;
    end else if (avs_address == fad_byte_addr(FAD_IDX_COARSE)) begin
      hit_coarse = 1'b1;
    end else if (avs_address == fad_byte_addr(FAD_IDX_FINE)) begin
      hit_fine = 1'b1;
    end
  end
  assign hit_any = hit_range || hit_coarse || hit_fine;

  // ****************************************************
  // Handshake state machine
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FAD_IDLE;
    end else if (ce) begin
      case (state_reg)
        // Request seen: answer at next edge
        FAD_IDLE: begin
          if (req) state_reg <= FAD_ACK;
        end
        // Completion edge
        FAD_ACK: begin
          state_reg <= FAD_IDLE;
        end
        default: begin
          state_reg <= FAD_IDLE;
        end
      endcase
    end
  end

  // Waitrequest drops in the completion cycle only
  assign avs_waitrequest = !(state_reg == FAD_ACK && ce);

  // Merge byte lanes of a write into a 16-bit word
  function automatic logic [15:0] fad_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    fad_merge = old;
    if (be[0]) fad_merge[7:0]  = wd[7:0];
    if (be[1]) fad_merge[15:8] = wd[15:8];
  endfunction

  // ****************************************************
  // Register writes
  // ****************************************************
  // RQ2 range default mid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      range_reg <= FAD_RST_RANGE;
    end else if (take && avs_write && hit_range) begin
      // RQ9 stores written value
      range_reg <= fad_merge(range_reg, avs_writedata, avs_byteenable);
    end
  end

  // RQ7 stabilizer default on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse_reg <= FAD_RST_COARSE;
    end else if (take && avs_write && hit_coarse) begin
      // RQ3 reserved bits stored as written
      coarse_reg <= fad_merge(coarse_reg, avs_writedata, avs_byteenable);
    end
  end

  // Fine delay register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fine_reg <= FAD_RST_FINE;
    end else if (take && avs_write && hit_fine) begin
      fine_reg <= fad_merge(fine_reg, avs_writedata, avs_byteenable);
    end
  end

  // ****************************************************
  // Read data and response
  // ****************************************************
  // RQ9 read back last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= 2'b00;
    end else if (ce && state_reg == FAD_IDLE && req) begin
      // Unmapped addresses answer with a decode error and zero data
      resp_reg <= hit_any ? 2'b00 : 2'b11;
      if (hit_range) begin
        rdata_reg <= {16'h0000, range_reg};
      end else if (hit_coarse) begin
        rdata_reg <= {16'h0000, coarse_reg};
      end else if (hit_fine) begin
        rdata_reg <= {16'h0000, fine_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;

  // ****************************************************
  // Applied control vectors
  // ****************************************************
  assign cfg.range_word  = range_reg;
  assign cfg.coarse_word = coarse_reg;
  assign cfg.fine_word   = fine_reg;

  fad_field_decode u_dec (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .cfg   (cfg)
  );

  assign range_magnitude        = cfg.range_magnitude;
  assign coarse_delay_magnitude = cfg.coarse_delay_magnitude;
  assign fine_delay_magnitude   = cfg.fine_delay_magnitude;
  assign delay_adjust_enable    = cfg.delay_adjust_enable;
  assign duty_stabilizer_enable = cfg.duty_stabilizer_enable;

  // ****************************************************
  // Checks
  // ****************************************************
  sequence s_req_seen;
    ce && state_reg == FAD_IDLE && req;
  endsequence

  sequence s_answer;
    !avs_waitrequest;
  endsequence

  // Answer one cycle after request when clock enabled
  AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    s_req_seen ##1 ce |-> s_answer) // RQ9
    else $error("Answer not given after one wait cycle");

  // RQ1 range drives field
  AST_RANGE_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> range_magnitude == $past(range_reg[14:0])) // RQ1
    else $error("Range field not driven");

  // RQ2 reset default present at reset release
  AST_RANGE_RST: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> range_reg == 16'h4000 && range_reg[14:0] == FAD_RANGE_MID) // RQ2
    else $error("Range default wrong");

  // RQ9 write then readback
  // A master may come back at once or one cycle after release
  AST_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
    (take && avs_write && hit_fine && avs_byteenable[1:0] == 2'b11)
      ##[1:2] (s_req_seen and (avs_read && hit_fine)) ##1 1'b1
      |-> avs_readdata[15:0] == $past(fine_reg)) // RQ9
    else $error("Readback differs");

  // Unmapped read returns zero
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    (s_req_seen and !hit_any) |=> avs_readdata == 32'h0000_0000 && avs_response == 2'b11) // RQ9
    else $error("Unmapped access answered wrongly");

  // ****************************************************
  // Handshake and storage checks
  // ****************************************************
  // Clock enable low over a sampled edge
  sequence s_frozen;
    !ce;
  endsequence

  // A write completes on this edge
  sequence s_write_done;
    take && avs_write;
  endsequence

  // RQ9 frozen keeps waitrequest
  AST_WAIT_FROZEN: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    s_frozen |-> avs_waitrequest)
    else $error("Waitrequest dropped while clock enable was low");

  // RQ9 no answer from idle
  AST_WAIT_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    state_reg == FAD_IDLE |-> avs_waitrequest)
    else $error("Waitrequest dropped before a request was seen");

  // RQ9 completion lasts one cycle
  AST_ACK_RETURNS: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    ce && state_reg == FAD_ACK |=> state_reg == FAD_IDLE)
    else $error("Handshake stayed in completion state");

  // RQ9 frozen state machine
  AST_STATE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    s_frozen |=> $stable(state_reg))
    else $error("Handshake state moved while clock enable was low");

  // RQ9 range holds without write
  AST_RANGE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    !(take && avs_write && hit_range) |=> $stable(range_reg))
    else $error("Range register changed without a write");

  // RQ9 coarse holds without write
  AST_COARSE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    !(take && avs_write && hit_coarse) |=> $stable(coarse_reg))
    else $error("Coarse register changed without a write");

  // RQ9 fine holds without write
  AST_FINE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    !(take && avs_write && hit_fine) |=> $stable(fine_reg))
    else $error("Fine register changed without a write");

  // RQ9 full range write stored
  AST_RANGE_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    (s_write_done and (hit_range && avs_byteenable[1:0] == 2'b11))
      |=> range_reg == $past(avs_writedata[15:0]))
    else $error("Range write not stored");

  // RQ9 full coarse write stored
  AST_COARSE_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    (s_write_done and (hit_coarse && avs_byteenable[1:0] == 2'b11))
      |=> coarse_reg == $past(avs_writedata[15:0]))
    else $error("Coarse write not stored");

  // RQ9 mapped access answers OK
  AST_MAPPED_OK: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    (s_req_seen and hit_any) |=> avs_response == 2'b00)
    else $error("Mapped access answered with an error");

  // RQ9 read data stand after completion
  AST_RDATA_STAND: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    state_reg == FAD_ACK |=> $stable(avs_readdata))
    else $error("Read data moved after completion");

  // RQ6 enable output follows bit
  AST_ENA_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    ce |=> delay_adjust_enable == $past(coarse_reg[FAD_ENA_BIT]))
    else $error("Delay adjust enable does not follow its bit");

  // RQ9 vectors frozen with enable low
  AST_OUT_FROZEN: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    s_frozen |=> $stable(range_magnitude)
      && $stable(coarse_delay_magnitude)
      && $stable(fine_delay_magnitude))
    else $error("Control vectors moved while clock enable was low");

endmodule

//--- verification/tb_top.sv
// Self-checking bench for the range and aperture delay register bank.
// Assumes fad_pkg and fad_regs are compiled first; one 25 MHz clock, Avalon-MM master here.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb_top;
  import fad_pkg::*;
  // ****************************************************
  // Signals and shadow state
  // ****************************************************
  logic        clk, rst_n, ce;            // Clock, reset, enable
  logic [7:0]  avs_address;               // Byte address
  logic        avs_read, avs_write;       // Request strobes
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response;
  logic        avs_waitrequest;
  logic [14:0] range_magnitude;
  logic [11:0] coarse_delay_magnitude;
  logic [5:0]  fine_delay_magnitude;
  logic        delay_adjust_enable, duty_stabilizer_enable;
  logic [15:0] sh [0:2];                  // Expected register contents
  logic [7:0]  addr_tab [0:2] = '{8'h2C, 8'h30, 8'h34};
  logic [31:0] lfsr = 32'hA20A22AC;       // Fixed seed keeps runs repeatable
  logic [31:0] rdat;
  logic [1:0]  resp;
  logic [11:0] code_tab [0:4] = '{12'h000, 12'h97F, 12'h980, 12'hFFF, 12'h001};
  int          err_total, comparisons;

  fad_regs fad_regs_i (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
    .range_magnitude(range_magnitude), .coarse_delay_magnitude(coarse_delay_magnitude),
    .fine_delay_magnitude(fine_delay_magnitude), .delay_adjust_enable(delay_adjust_enable),
    .duty_stabilizer_enable(duty_stabilizer_enable));

  // Clock, 40 ns period
  always #20 clk = ~clk;

  // ****************************************************
  // Helpers
  // ****************************************************
  // Fibonacci-style shift register for stimulus
  function automatic logic [31:0] nxt(input logic [31:0] x);
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Applied coarse magnitude: saturates, zero while adjustment is off
  function automatic logic [11:0] exp_coarse(input logic [15:0] w);
    exp_coarse = !w[3] ? 12'h000 : (w[15:4] > 12'h97F) ? 12'h97F : w[15:4];
  endfunction

  // One bus transfer; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED at %0t: no answer on bus", $time);
    end
    rdat = avs_readdata;
    resp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Write a register and track it in the shadow, lane by lane
  task automatic wr_reg(input int i, input logic [15:0] d, input logic [3:0] be);
    bus(1'b1, addr_tab[i], d, be);
    if (be[0]) sh[i][7:0] = d[7:0];
    if (be[1]) sh[i][15:8] = d[15:8];
  endtask

  // Read a register and compare against the shadow
  task automatic rd_chk(input int i);
    bus(1'b0, addr_tab[i], 16'h0000, 4'hF);
    `CHK(rdat, {16'h0000, sh[i]})
    `CHK(resp, 2'b00)
  endtask

  // Compare the static control vectors once the write has landed
  task automatic chk_out();
    repeat (2) @(negedge clk);
    `CHK(range_magnitude, sh[0][14:0])
    `CHK(coarse_delay_magnitude, exp_coarse(sh[1]))
    `CHK(fine_delay_magnitude, sh[1][3] ? sh[2][15:10] : 6'h00)
    `CHK(delay_adjust_enable, sh[1][3])
    `CHK(duty_stabilizer_enable, sh[1][2])
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************************
  // Watchdog, well above the few hundred cycles expected
  // ****************************************************
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    clk = 1'b0; rst_n = 1'b0; ce = 1'b1; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; err_total = 0; comparisons = 0;
    sh[0] = 16'h4000; sh[1] = 16'h0004; sh[2] = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset defaults on registers and outputs
    chk_out();
    for (int i = 0; i < 3; i++) rd_chk(i);
    $display("test reset done");
    // Coarse corners around saturation, with enable and stabilizer combinations
    for (int i = 0; i < 10; i++) begin
      wr_reg(0, (i % 2) ? 16'h7FFF : 16'h0000, 4'h3);
      wr_reg(1, {code_tab[i % 5], i < 5 ? 1'b1 : 1'b0, i[0], 2'b00}, 4'h3);
      wr_reg(2, {(i % 3 == 0) ? 6'h3F : 6'h00, 10'h000}, 4'h3);
      rd_chk(2);
      chk_out();
      rd_chk(1);
    end
    $display("test corners done");
    // Random traffic with legal reserved bits and random lanes
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      case (lfsr[1:0])
        2'd0: wr_reg(0, {1'b0, lfsr[30:16]}, lfsr[7:4]);
        2'd1: wr_reg(1, {lfsr[27:16], lfsr[8], lfsr[9], 2'b00}, lfsr[7:4]);
        default: wr_reg(2, {lfsr[21:16], 10'h000}, lfsr[7:4]);
      endcase
      rd_chk(lfsr[12] ? 1 : (lfsr[13] ? 2 : 0));
      chk_out();
    end
    $display("test random done");
    // Unmapped places: write ignored, read gives zero with error code
    bus(1'b1, 8'h28, 16'hFFFF, 4'hF);
    bus(1'b1, 8'h38, 16'hFFFF, 4'hF);
    bus(1'b0, 8'h38, 16'h0000, 4'hF);
    `CHK(rdat, 32'h0)
    `CHK(resp, 2'b11)
    for (int i = 0; i < 3; i++) rd_chk(i);
    chk_out();
    $display("test unmapped done");
    // Frozen clock enable: a pending read must wait, stabilizer output steady, then it completes
    @(posedge clk);
    ce          <= 1'b0;
    avs_address <= addr_tab[1];
    avs_read    <= 1'b1;
    repeat (3) begin
      @(negedge clk);
      `CHK(avs_waitrequest, 1'b1)
      `CHK(duty_stabilizer_enable, sh[1][2])
    end
    @(posedge clk);
    ce <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    `CHK(avs_readdata, {16'h0000, sh[1]})
    `CHK(avs_response, 2'b00)
    avs_read <= 1'b0;
    chk_out();
    $display("test enable done");
    wrap_up();
  end
endmodule
